// ===== rtl/ebi_top.sv
`timescale 1ns/1ns
module ebi_top
    import ebi_pkg::*;
#(
    parameter int PULL_GROUPS = 12
)
(
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // straps and configuration levels
    input wire logic BOOT_MODE_PIN,
    input wire logic BYTE_WIDTH_PIN,
    input wire logic SW_EXPAND,
    input wire logic STROBE_SCHEME,
    input wire logic MUX_MODE,
    input wire logic [1:0] CLOCK_OUT_SEL,
    // internal access request
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_WORD,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    output logic REQ_READY,
    // internal access answer
    output logic RESP_VALID,
    output logic [DATA_W-1:0] RESP_RDATA,
    // address pins
    output logic [ADDR_W-1:0] ADDR_OUT,
    output logic [ADDR_W-1:0] ADDR_OE,
    input wire logic [MUXIN_W-1:0] ADDR_IN,
    // data pins
    output logic [DATA_W-1:0] DATA_OUT,
    output logic [1:0] DATA_OE,
    input wire logic [DATA_W-1:0] DATA_IN,
    // strobes and selects
    output logic LOW_BYTE_STORE_STROBE_N,
    output logic HIGH_BYTE_STORE_STROBE_N,
    output logic RD_N,
    output logic ALE,
    output logic [CS_NUM-1:0] CHIP_SELECT_N,
    output logic CTRL_OE,
    output logic BUS_CLK_OUT,
    // bus release and wait
    input wire logic HOLD_N,
    output logic BUS_RELEASE_ACK_N,
    input wire logic WAIT_REQ_N,
    // nmi
    input wire logic NMI_IN,
    output logic NMI_REQ,
    // clock output pin
    input wire logic SUB_OSC_IN,
    output logic CLOCK_OUT_PIN,
    // processor mode and pull-ups
    output logic [1:0] PROC_MODE,
    input wire logic [PULL_GROUPS-1:0] PULLUP_SEL,
    input wire logic [PULL_GROUPS-1:0] PORT_DIR_IN,
    output logic [PULL_GROUPS-1:0] PULLUP_EN
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (PULL_GROUPS < 1)
    begin : g_bad_groups
        $error("PULL_GROUPS must be at least one");
    end
    if (CS_LSB + $clog2(CS_NUM) != ADDR_W)
    begin : g_bad_cs
        $error("chip select field must reach the top address bit");
    end

    // ************************************************************
    // state and helpers
    // ************************************************************
    ebi_regs_type s; // registered state
    ebi_regs_type next_s; // next state
    logic bus_on; // an external bus mode is active
    logic step; // bus clock falling edge: bus phases advance
    logic [7:0] rd_lo; // low lane as seen at the pins
    logic [7:0] rd_hi; // high lane as seen at the pins
    logic [19:0] mux_mask; // address pins shared with data

    assign bus_on = s.mode_valid && (s.mode != MODE_SINGLE);
    assign step = s.bclk;

    // shared pins depend on the width latched with the access
    always_comb
    begin
        mux_mask = 20'h0_0000;
        if (s.mux)
        begin
            mux_mask = s.byte8 ? MUX8_MASK : MUX16_MASK;
        end
    end

    // read lanes: low lane from shared address pins in mux mode, data pins else; high lane always from data pins
    always_comb
    begin
        rd_hi = DATA_IN[15:8];
        if (s.mux && s.byte8)
        begin
            rd_lo = ADDR_IN[7:0];
        end
        else if (s.mux)
        begin
            rd_lo = ADDR_IN[8:1];
        end
        else
        begin
            rd_lo = DATA_IN[7:0];
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_s = s;
        next_s.resp = 1'b0;
        next_s.nmi_req = 1'b0;

        // processor mode: boot level caught once after reset release
        if (!s.mode_valid)
        begin
            next_s.mode_valid = 1'b1;
            next_s.mode = BOOT_MODE_PIN ? MODE_MICRO : MODE_SINGLE;
        end
        else if (s.mode != MODE_MICRO)
        begin
            next_s.mode = SW_EXPAND ? MODE_EXPAND : MODE_SINGLE;
        end

        // nmi: high-to-low edge, no enable exists
        next_s.nmi_prev = NMI_IN;
        if (s.nmi_prev && !NMI_IN)
        begin
            next_s.nmi_req = 1'b1;
        end

        // clock output divider and sub clock synchroniser
        next_s.div_cnt = s.div_cnt + 5'h01;
        next_s.sub_s1 = SUB_OSC_IN;
        next_s.sub_s2 = s.sub_s1;
        case (CLOCK_OUT_SEL)
            CKO_DIV8: next_s.clk_out = s.div_cnt[DIV8_BIT];
            CKO_DIV32: next_s.clk_out = s.div_cnt[DIV32_BIT];
            CKO_SUB: next_s.clk_out = s.sub_s2;
            default: next_s.clk_out = 1'b0;
        endcase
        if (s.mode != MODE_SINGLE)
        begin
            next_s.clk_out = 1'b0;
        end

        // bus clock runs at half the core rate in bus modes
        next_s.bclk = bus_on ? ~s.bclk : 1'b0;

        if (!bus_on)
        begin
            // single-chip: bus pins belong to the ports
            next_s.st = ST_IDLE;
            next_s.ctrl_oe = 1'b0;
            next_s.addr_oe = 20'h0_0000;
            next_s.data_oe = 2'h0;
            next_s.cs_n = 4'hf;
            next_s.ack_n = 1'b1;
        end
        else if (step)
        begin
            case (s.st)
                // idle: hold has priority over a new access
                ST_IDLE:
                begin
                    if (!HOLD_N)
                    begin
                        next_s.st = ST_HOLD;
                        next_s.ack_n = 1'b0;
                        next_s.ctrl_oe = 1'b0;
                        next_s.addr_oe = 20'h0_0000;
                        next_s.data_oe = 2'h0;
                    end
                    else
                    begin
                        next_s.ctrl_oe = 1'b1;
                        next_s.addr_oe = ALL_ADDR;
                        if (REQ_VALID)
                        begin
                            next_s.st = ST_ADDR;
                            next_s.write = REQ_WRITE;
                            next_s.byte8 = BYTE_WIDTH_PIN;
                            next_s.mux = MUX_MODE;
                            next_s.scheme = STROBE_SCHEME;
                            next_s.odd = REQ_ADDR[0];
                            next_s.word = REQ_WORD && !BYTE_WIDTH_PIN;
                            // byte lanes: high lane only on a sixteen-bit bus
                            next_s.lane[0] = BYTE_WIDTH_PIN || REQ_WORD || !REQ_ADDR[0];
                            next_s.lane[1] = !BYTE_WIDTH_PIN && (REQ_WORD || REQ_ADDR[0]);
                            if (!BYTE_WIDTH_PIN && !REQ_WORD && REQ_ADDR[0])
                            begin
                                next_s.wdata = {REQ_WDATA[7:0], 8'h00};
                            end
                            else
                            begin
                                next_s.wdata = REQ_WDATA;
                            end
                            next_s.addr_out = REQ_ADDR;
                            next_s.ale = MUX_MODE;
                            next_s.cs_n = ~(4'h1 << REQ_ADDR[ADDR_W-1:CS_LSB]);
                        end
                    end
                end
                // address phase over: strobes go active
                ST_ADDR:
                begin
                    next_s.st = ST_STROBE;
                    next_s.ale = 1'b0;
                    if (s.scheme)
                    begin
                        next_s.wra_n = ~s.write;
                        next_s.wrb_n = ~s.lane[1] & ~(s.byte8 & s.odd);
                    end
                    else
                    begin
                        next_s.wra_n = ~(s.write & s.lane[0]);
                        next_s.wrb_n = ~(s.write & s.lane[1]);
                    end
                    next_s.rd_n = s.write;
                    if (s.write)
                    begin
                        if (s.mux && s.byte8)
                        begin
                            next_s.addr_out[7:0] = s.wdata[7:0];
                            next_s.data_oe = 2'h0;
                        end
                        else if (s.mux)
                        begin
                            next_s.addr_out[8:1] = s.wdata[7:0];
                            next_s.data_out[15:8] = s.wdata[15:8];
                            next_s.data_oe = {s.lane[1], 1'b0};
                        end
                        else
                        begin
                            next_s.data_out = s.wdata;
                            next_s.data_oe = s.lane;
                        end
                    end
                    else
                    begin
                        // reads release the shared pins for the far side
                        next_s.addr_oe = ALL_ADDR & ~mux_mask;
                        next_s.data_oe = 2'h0;
                    end
                end
                // strobe phase: each low wait sample adds a bus cycle
                ST_STROBE:
                begin
                    if (WAIT_REQ_N)
                    begin
                        next_s.st = ST_DONE;
                        next_s.wra_n = 1'b1;
                        next_s.wrb_n = 1'b1;
                        next_s.rd_n = 1'b1;
                        if (s.word)
                        begin
                            next_s.rdata = {rd_hi, rd_lo};
                        end
                        else if (!s.byte8 && s.odd)
                        begin
                            next_s.rdata = {8'h00, rd_hi};
                        end
                        else
                        begin
                            next_s.rdata = {8'h00, rd_lo};
                        end
                    end
                end
                // recovery: selects drop, answer goes out
                ST_DONE:
                begin
                    next_s.st = ST_IDLE;
                    next_s.cs_n = 4'hf;
                    next_s.data_oe = 2'h0;
                    next_s.addr_oe = ALL_ADDR;
                    next_s.addr_out = s.addr_out & ~mux_mask;
                    next_s.resp = 1'b1;
                end
                // hold: pins floated until the request goes away
                ST_HOLD:
                begin
                    if (HOLD_N)
                    begin
                        next_s.st = ST_IDLE;
                        next_s.ack_n = 1'b1;
                        next_s.ctrl_oe = 1'b1;
                        next_s.addr_oe = ALL_ADDR;
                    end
                end
                default:
                begin
                    next_s.st = ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    // reset low holds everything at its reset value
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s <= EBI_RESET;
        end
        else if (CE)
        begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // new access taken only at a bus edge in idle without hold
    assign REQ_READY = CE && bus_on && step && (s.st == ST_IDLE) && HOLD_N;
    assign RESP_VALID = s.resp;
    assign RESP_RDATA = s.rdata;
    assign ADDR_OUT = s.addr_out;
    assign ADDR_OE = s.addr_oe;
    assign DATA_OUT = s.data_out;
    assign DATA_OE = s.data_oe;
    assign LOW_BYTE_STORE_STROBE_N = s.wra_n;
    assign HIGH_BYTE_STORE_STROBE_N = s.wrb_n;
    assign RD_N = s.rd_n;
    assign ALE = s.ale;
    assign CHIP_SELECT_N = s.cs_n;
    assign CTRL_OE = s.ctrl_oe;
    assign BUS_CLK_OUT = s.bclk;
    assign BUS_RELEASE_ACK_N = s.ack_n;
    assign NMI_REQ = s.nmi_req;
    assign CLOCK_OUT_PIN = s.clk_out;
    assign PROC_MODE = s.mode;

    // ************************************************************
    // pull-up groups
    // ************************************************************
    // one enable per nibble, off for every group in bus modes
    for (genvar g = 0; g < PULL_GROUPS; g++)
    begin : g_pull
        assign PULLUP_EN[g] = PULLUP_SEL[g] && PORT_DIR_IN[g] && !bus_on;
    end

endmodule : ebi_top

// ===== rtl/ebi_pkg.sv
// Notes on behaviour
// - width pin low sixteen-bit, high eight-bit bus
// - byte-lane scheme: even low strobe, odd high on sixteen-bit bus; eight-bit bus uses the low strobe only
// - single store strobe; upper enable low on odd
// - scheme chosen by input, strobes never mixed
// - bus-release request low enters hold, ack low
// - wait request low stretches the access
// - address latch strobe marks multiplexed address phase
// - eight-bit mux shares address and data low byte
// - sixteen-bit mux shares address one to eight
// - separate mode uses dedicated address and data pins
// - four chip selects decode top address bits
// - boot pin level picks processor mode after reset
// - reset input low holds all state
// - falling edge on nmi pin raises request
// - single-chip clock out: div8, div32, sub
// - pull-ups per nibble, ignored in bus modes
package ebi_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int CS_NUM = 4;
    localparam int CS_LSB = 18;
    localparam int MUXIN_W = 9;

    // ****************************************
    // encodings
    // ****************************************
    // processor modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_EXPAND = 2'h1;
    localparam logic [1:0] MODE_MICRO = 2'h3;
    // clock output selections
    localparam logic [1:0] CKO_OFF = 2'h0;
    localparam logic [1:0] CKO_DIV8 = 2'h1;
    localparam logic [1:0] CKO_DIV32 = 2'h2;
    localparam logic [1:0] CKO_SUB = 2'h3;
    // divider ratios and counter taps derived from them
    localparam int DIV8_RATIO = 8;
    localparam int DIV32_RATIO = 32;
    localparam int DIV8_BIT = $clog2(DIV8_RATIO) - 1;
    localparam int DIV32_BIT = $clog2(DIV32_RATIO) - 1;
    localparam int DIV_W = DIV32_BIT + 1;
    // address pins that carry data in the multiplexed modes
    localparam logic [19:0] MUX8_MASK = 20'h0_00ff;
    localparam logic [19:0] MUX16_MASK = 20'h0_01fe;
    localparam logic [19:0] ALL_ADDR = 20'hf_ffff;

    // ****************************************
    // state
    // ****************************************
    typedef enum {ST_IDLE, ST_ADDR, ST_STROBE, ST_DONE, ST_HOLD} ebi_phase_type;

    typedef struct packed {
        ebi_phase_type st;
        logic bclk;
        logic write;
        logic byte8;
        logic mux;
        logic scheme;
        logic [1:0] lane;
        logic odd;
        logic word;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic resp;
        logic ale;
        logic rd_n;
        logic wra_n;
        logic wrb_n;
        logic ctrl_oe;
        logic [ADDR_W-1:0] addr_out;
        logic [ADDR_W-1:0] addr_oe;
        logic [DATA_W-1:0] data_out;
        logic [1:0] data_oe;
        logic [CS_NUM-1:0] cs_n;
        logic ack_n;
        logic nmi_prev;
        logic nmi_req;
        logic [1:0] mode;
        logic mode_valid;
        logic [DIV_W-1:0] div_cnt;
        logic clk_out;
        logic sub_s1;
        logic sub_s2;
    } ebi_regs_type;

    // ****************************************
    // values after reset
    // ****************************************
    // active-low strobes, selects and ack idle high, nmi_prev high; all else zero
    localparam ebi_regs_type EBI_RESET = '{
        st: ST_IDLE, rd_n: 1'b1, wra_n: 1'b1, wrb_n: 1'b1, cs_n: 4'hf,
        ack_n: 1'b1, nmi_prev: 1'b1, default: '0};

endpackage : ebi_pkg

// ===== testbench/ebi_properties.sv
`timescale 1ns/1ns
module ebi_checker
    import ebi_pkg::*;
#(
    parameter int PULL_GROUPS = 12
)
(
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // configuration levels
    input wire logic BYTE_WIDTH_PIN,
    input wire logic MUX_MODE,
    // request and answer
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_READY,
    input wire logic RESP_VALID,
    // bus pins
    input wire logic [ADDR_W-1:0] ADDR_OUT,
    input wire logic [ADDR_W-1:0] ADDR_OE,
    input wire logic [1:0] DATA_OE,
    input wire logic LOW_BYTE_STORE_STROBE_N,
    input wire logic RD_N,
    input wire logic ALE,
    input wire logic [CS_NUM-1:0] CHIP_SELECT_N,
    input wire logic CTRL_OE,
    input wire logic BUS_CLK_OUT,
    // release, wait, nmi, mode
    input wire logic HOLD_N,
    input wire logic BUS_RELEASE_ACK_N,
    input wire logic WAIT_REQ_N,
    input wire logic NMI_IN,
    input wire logic NMI_REQ,
    input wire logic [1:0] PROC_MODE,
    input wire logic [PULL_GROUPS-1:0] PULLUP_EN
);
    // ****************************************
    // one clock domain for every property
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    property p_ready;
        REQ_READY |-> BUS_CLK_OUT && HOLD_N && BUS_RELEASE_ACK_N && PROC_MODE != MODE_SINGLE;
    endproperty
    a_ready: assert property (p_ready) else $error("ready outside idle bus");
    property p_float;
        !BUS_RELEASE_ACK_N |-> !CTRL_OE && ADDR_OE == '0 && DATA_OE == '0;
    endproperty
    a_float: assert property (p_float) else $error("pins driven in hold");
    property p_ale;
        REQ_VALID && REQ_READY && CE |=> ALE == MUX_MODE ##2 !ALE;
    endproperty
    a_ale: assert property (p_ale) else $error("latch strobe wrong");
    property p_rd;
        REQ_VALID && REQ_READY && CE && !REQ_WRITE |-> ##3 !RD_N && LOW_BYTE_STORE_STROBE_N;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe late");
    property p_wait;
        CE && !RD_N && BUS_CLK_OUT && !WAIT_REQ_N |=> !RD_N [*2];
    endproperty
    a_wait: assert property (p_wait) else $error("wait not honoured");
    property p_end;
        CE && !RD_N && BUS_CLK_OUT && WAIT_REQ_N |=> RD_N ##2 RESP_VALID;
    endproperty
    a_end: assert property (p_end) else $error("access end wrong");
    property p_cs;
        !RD_N || !LOW_BYTE_STORE_STROBE_N |-> CHIP_SELECT_N == ~(4'h1 << ADDR_OUT[19:18]);
    endproperty
    a_cs: assert property (p_cs) else $error("chip select decode");
    property p_byte8;
        !LOW_BYTE_STORE_STROBE_N && BYTE_WIDTH_PIN |-> DATA_OE[1] == 1'b0;
    endproperty
    a_byte8: assert property (p_byte8) else $error("high lane on byte bus");
    property p_nmi;
        CE && $fell(NMI_IN) |=> NMI_REQ;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi edge missed");
    property p_pull;
        PROC_MODE != MODE_SINGLE |-> PULLUP_EN == '0;
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up in bus mode");
endmodule : ebi_checker

bind ebi_top ebi_checker #(.PULL_GROUPS(PULL_GROUPS)) ebi_checker_i (.*);

// ===== testbench/ebi_mem_model.sv
`timescale 1ns/1ns
module ebi_mem_model
    import ebi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus arrangement and wait length
    input wire logic byte8,
    input wire logic mux,
    input wire logic scheme,
    input wire logic [3:0] wait_cnt,
    // device pins
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic lo_n,
    input wire logic hi_n,
    input wire logic rd_n,
    input wire logic ale,
    input wire logic bclk,
    output logic [DATA_W-1:0] data_in,
    output logic [MUXIN_W-1:0] addr_in,
    output logic wait_n
);
    logic [7:0] mem [0:255]; // byte storage
    logic [ADDR_W-1:0] lat; // latched address
    logic [3:0] used; // wait samples spent
    logic [15:0] junk = 16'h0000; // released bus pattern
    logic [7:0] a, la, ha, wl;
    logic act;

    // lane addresses, read drive and wait request
    always_comb
    begin
        a = mux ? lat[7:0] : addr_out[7:0];
        la = byte8 ? a : {a[7:1], 1'b0};
        ha = {a[7:1], 1'b1};
        wl = !mux ? data_out[7:0] : byte8 ? addr_out[7:0] : addr_out[8:1];
        act = !rd_n || !lo_n || (!scheme && !hi_n);
        wait_n = !(act && used < wait_cnt);
        data_in = rd_n ? junk : {mem[ha], mem[la]};
        addr_in = rd_n ? junk[8:0] : byte8 ? {junk[0], mem[la]} : {mem[la], junk[0]};
    end

    // latch, wait count and store
    always_ff @(posedge clk)
    begin
        junk <= junk + 16'h3c5b;
        if (ale)
            lat <= addr_out;
        used <= act ? used + {3'h0, bclk} : 4'h0;
        if (reset_n && !lo_n && (!scheme || byte8 || !a[0]))
            mem[la] <= wl;
        if (reset_n && !byte8 && !hi_n && (!scheme || !lo_n))
            mem[ha] <= data_out[15:8];
    end
endmodule : ebi_mem_model

// ===== testbench/ebi_top_test.sv
`timescale 1ns/1ns
module ebi_top_test;
    import ebi_pkg::*;
    // ****************************************
    // design pins and bench state
    // ****************************************
    logic CLK, RESET_N, CE, BOOT_MODE_PIN, BYTE_WIDTH_PIN, SW_EXPAND, STROBE_SCHEME;
    logic MUX_MODE, REQ_VALID, REQ_WRITE, REQ_WORD, REQ_READY, RESP_VALID;
    logic [1:0] CLOCK_OUT_SEL, DATA_OE, PROC_MODE;
    logic [ADDR_W-1:0] REQ_ADDR, ADDR_OUT, ADDR_OE;
    logic [DATA_W-1:0] REQ_WDATA, RESP_RDATA, DATA_OUT, DATA_IN;
    logic [MUXIN_W-1:0] ADDR_IN;
    logic LOW_BYTE_STORE_STROBE_N, HIGH_BYTE_STORE_STROBE_N, RD_N, ALE, CTRL_OE, BUS_CLK_OUT;
    logic [CS_NUM-1:0] CHIP_SELECT_N;
    logic HOLD_N, BUS_RELEASE_ACK_N, WAIT_REQ_N, NMI_IN, NMI_REQ, SUB_OSC_IN, CLOCK_OUT_PIN;
    logic [11:0] PULLUP_SEL, PORT_DIR_IN, PULLUP_EN;
    logic [3:0] wait_cnt;
    int num_errors = 0, total_checks = 0, cycles = 0, sub_cnt = 0;

    ebi_top ebi_top_i (.*);
    ebi_mem_model ebi_mem_model_i (.clk(CLK), .reset_n(RESET_N), .byte8(BYTE_WIDTH_PIN),
        .mux(MUX_MODE), .scheme(STROBE_SCHEME), .wait_cnt(wait_cnt), .addr_out(ADDR_OUT),
        .data_out(DATA_OUT), .lo_n(LOW_BYTE_STORE_STROBE_N), .hi_n(HIGH_BYTE_STORE_STROBE_N),
        .rd_n(RD_N), .ale(ALE), .bclk(BUS_CLK_OUT), .data_in(DATA_IN), .addr_in(ADDR_IN),
        .wait_n(WAIT_REQ_N));

    // core clock
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // sub clock of 14 cycles and hang limit
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        sub_cnt <= sub_cnt == 6 ? 0 : sub_cnt + 1;
        if (sub_cnt == 6)
            SUB_OSC_IN <= ~SUB_OSC_IN;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic do_reset(input logic boot, input logic swx, input logic [1:0] mode);
        @(posedge CLK);
        RESET_N <= 1'b0;
        BOOT_MODE_PIN <= boot;
        SW_EXPAND <= swx;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        chk("proc_mode", PROC_MODE, mode);
    endtask : do_reset

    // one access; byte results sit in the low byte
    task automatic acc(input logic w, input logic k, input logic [19:0] a,
        input logic [15:0] d, input logic [3:0] nw, input logic [15:0] exp);
        int n = 0;
        logic l = 0, h = 0, r = 0;
        @(posedge CLK);
        wait_cnt <= nw;
        REQ_VALID <= 1'b1;
        REQ_WRITE <= w;
        REQ_WORD <= k;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        @(negedge CLK);
        while (REQ_READY !== 1'b1 && n++ < 50)
            @(negedge CLK);
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        n = 0;
        while (RESP_VALID !== 1'b1 && n < 60)
        begin
            @(negedge CLK);
            n++;
            l |= !LOW_BYTE_STORE_STROBE_N;
            h |= !HIGH_BYTE_STORE_STROBE_N;
            r |= !RD_N;
        end
        chk("latency", n, 7 + 2 * nw);
        chk("read_strobe", r, !w);
        if (w && (STROBE_SCHEME || !BYTE_WIDTH_PIN))
        begin
            chk("low_strobe", l, STROBE_SCHEME || !a[0] || k);
            chk("high_strobe", h, a[0] || (k && !BYTE_WIDTH_PIN));
        end
        if (!w)
            chk("read_data", RESP_RDATA & (k ? 16'hffff : 16'h00ff), exp);
    endtask : acc

    // ****************************************
    // scenarios
    // ****************************************
    // every width, arrangement and strobe scheme, with waits
    task automatic t_modes();
        logic [19:0] a;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge CLK);
            {STROBE_SCHEME, MUX_MODE, BYTE_WIDTH_PIN} <= i[2:0];
            a = {i[1:0], 10'h155, i[4:0], 3'h0};
            acc(1, 0, a, 16'h00c3 ^ 16'(i), 0, 0);
            acc(1, 0, a | 1, 16'h005a + 16'(i), 1, 0);
            acc(0, 0, a, 0, 0, 16'h00c3 ^ 16'(i));
            acc(0, 0, a | 1, 0, 2, 16'h005a + 16'(i));
            if (!i[0])
            begin
                acc(1, 1, a, 16'h9e00 | 16'(i), 0, 0);
                acc(0, 1, a, 0, 1, 16'h9e00 | 16'(i));
            end
        end
    endtask : t_modes

    // bus release while a request waits
    task automatic t_hold();
        logic f = 0;
        @(posedge CLK);
        HOLD_N <= 1'b0;
        repeat (4) @(negedge CLK);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        repeat (12)
        begin
            @(negedge CLK);
            f |= REQ_READY | CTRL_OE | (|ADDR_OE) | (|DATA_OE) | BUS_RELEASE_ACK_N;
        end
        chk("hold_float", f, 0);
        @(posedge CLK);
        HOLD_N <= 1'b1;
        REQ_VALID <= 1'b0;
        repeat (6) @(negedge CLK);
        chk("hold_end", BUS_RELEASE_ACK_N, 1);
        acc(1, 0, 20'h3_0010, 16'h0077, 0, 0);
        acc(0, 0, 20'h3_0010, 0, 0, 16'h0077);
    endtask : t_hold

    // one request per falling edge only
    task automatic t_nmi();
        logic [2:0] c = 0;
        for (int k = 0; k < 12; k++)
        begin
            @(posedge CLK);
            NMI_IN <= k > 5;
            @(negedge CLK);
            c += NMI_REQ;
        end
        chk("nmi_pulses", c, 1);
    endtask : t_nmi

    // gap between two rises of the clock output pin
    task automatic rise_gap(output int n);
        n = 0;
        for (int v = 0; v < 2; v++)
        begin
            while (CLOCK_OUT_PIN !== v[0] && n++ < 80)
                @(negedge CLK);
        end
    endtask : rise_gap

    // strap modes, refusal and clock output in single chip
    task automatic t_single();
        int n;
        logic f = 0;
        int per [1:3] = '{8, 32, 14};
        do_reset(0, 1, MODE_EXPAND);
        do_reset(0, 0, MODE_SINGLE);
        chk("pullup_single", |PULLUP_EN, 1);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        repeat (20)
        begin
            @(negedge CLK);
            f |= REQ_READY | BUS_CLK_OUT;
        end
        chk("single_refuse", f, 0);
        for (int s = 1; s < 4; s++)
        begin
            @(posedge CLK);
            REQ_VALID <= 1'b0;
            CLOCK_OUT_SEL <= s[1:0];
            rise_gap(n);
            rise_gap(n);
            chk("clock_out_period", n, per[s]);
        end
    endtask : t_single

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        RESET_N = 1'b0;
        CE = 1'b1;
        {BOOT_MODE_PIN, BYTE_WIDTH_PIN, SW_EXPAND, STROBE_SCHEME, MUX_MODE} = 5'h10;
        {REQ_VALID, REQ_WRITE, REQ_WORD, REQ_ADDR, REQ_WDATA} = '0;
        {HOLD_N, NMI_IN, SUB_OSC_IN, CLOCK_OUT_SEL, wait_cnt} = 9'h180;
        PULLUP_SEL = 12'hfff;
        PORT_DIR_IN = 12'h0f0;
        do_reset(1, 0, MODE_MICRO);
        t_modes();
        t_hold();
        t_nmi();
        t_single();
        end_sim();
    end
endmodule : ebi_top_test
